// [shared/ciu_pkg.sv]
`default_nettype none
package ciu_pkg;

  // ==========================================================================
  // sizes
  localparam int CIU_CHANNELS = 32;
  localparam int CIU_IDX_W    = 5;
  localparam int CIU_ADDR_W   = 8;
  localparam int CIU_DATA_W   = 32;
  localparam int CIU_SYNC_LEN = 2;

  // ==========================================================================
  // register byte offsets
  localparam logic [7:0] CIU_PEND_OFS     = 8'h00;
  localparam logic [7:0] CIU_ENABLE_OFS   = 8'h04;
  localparam logic [7:0] CIU_FAST_SEL_OFS = 8'h08;
  localparam logic [7:0] CIU_FAST_VEC_OFS = 8'h0C;
  localparam logic [7:0] CIU_NORM_VEC_OFS = 8'h10;
  localparam logic [7:0] CIU_SOFT_SET_OFS = 8'h14;
  localparam logic [7:0] CIU_RAW_OFS      = 8'h18;
  localparam logic [7:0] CIU_EDGE_SEL_OFS = 8'h1C;
  localparam logic [7:0] CIU_MISS_OFS     = 8'h20;

  // ==========================================================================
  // reset values and field positions
  localparam logic [31:0] CIU_PEND_RST     = 32'h0000_0000;
  localparam logic [31:0] CIU_ENABLE_RST   = 32'h0000_0000;
  localparam logic [31:0] CIU_FAST_SEL_RST = 32'h0000_0000;
  localparam logic [31:0] CIU_EDGE_SEL_RST = 32'hFFFF_FFFF;
  localparam int          CIU_VEC_VALID_BIT = 8;

  // ==========================================================================
  // channel numbers, precedence rises with the number
  localparam int CIU_CH_BROWNOUT    = 0;
  localparam int CIU_CH_EXT_PIN     = 1;
  localparam int CIU_CH_WD_EXPIRY   = 2;
  localparam int CIU_CH_WD_WAKE     = 3;
  localparam int CIU_CH_SER_ERR     = 4;
  localparam int CIU_CH_SER0_RX     = 5;
  localparam int CIU_CH_SER0_TX     = 6;
  localparam int CIU_CH_SER1_RX     = 7;
  localparam int CIU_CH_SER1_TX     = 8;
  localparam int CIU_CH_PWR_BUS     = 9;
  localparam int CIU_CH_DIG_COMP    = 10;
  localparam int CIU_CH_FRONT_END0  = 11;
  localparam int CIU_CH_TMOD3       = 14;
  localparam int CIU_CH_WT_OVF      = 18;
  localparam int CIU_CH_DT_FAULT    = 19;
  localparam int CIU_CH_WT_CMP1     = 20;
  localparam int CIU_CH_WT_CAP0     = 21;
  localparam int CIU_CH_WT_CMP0     = 22;
  localparam int CIU_CH_PWR_CUR     = 23;
  localparam int CIU_CH_CONV_DONE   = 24;
  localparam int CIU_CH_FAULT_MUX   = 25;
  localparam int CIU_CH_PMOD3       = 26;
  localparam int CIU_CH_FAULT_PIN   = 30;
  localparam int CIU_CH_SOFTWARE    = 31;

endpackage : ciu_pkg
`default_nettype wire

// [rtl/ciu_prio_enc.sv]
`timescale 1ns/100ps
`default_nettype none
module ciu_prio_enc (
  input  wire logic [ciu_pkg::CIU_CHANNELS-1:0] request_in, // eligible pending channels
  output logic      [ciu_pkg::CIU_IDX_W-1:0]    index_out,  // highest set channel
  output logic                                  found_out   // any channel set
);
  import ciu_pkg::*;

  // ==========================================================================
  // ascending scan, so the last hit is the highest channel
  always_comb
  begin
    index_out = '0;
    found_out = 1'b0;
    for (int i = 0; i < CIU_CHANNELS; i++)
    begin
      if (request_in[i])
      begin
        index_out = CIU_IDX_W'(i); // R04
        found_out = 1'b1;
      end
    end
  end

endmodule : ciu_prio_enc
`default_nettype wire

// [rtl/ciu_top.sv]
// Notes on behaviour
// R01: thirty-two request channels feed the core
// R02: fast and normal levels, fast wins
// R03: per level, vector gives highest pending channel
// R04: higher channel number means higher precedence
// R05: firmware clears request first in handler
// R06: each channel has its own enable bit
// R07: channel 0 brownout, 1 external pin
// R08: channel 2 watchdog expiry, 3 wake
// R09: channel 4 serial frame, parity, overrun error
// R10: channels 5-8 serial receive and transmit
// R11: channels 9 bus, 10 comparator, 24 conversion
// R12: channels 11-13 front ends, six causes each
// R13: channels 14-17 timer modulators 3 to 0
// R14: channels 18-22 wide timer and dead-time fault
// R15: channel 23 power/current mode switch
// R16: channel 25 fault mux, 30 fault pin
// R17: channels 26-29 pulse modulators 3 to 0
// R18: masked stays pending, excluded, cleared by firmware
//
// The implementer's own choices: strobed register access and the address map.
`timescale 1ns/100ps
`default_nettype none
module ciu_top (
  input  wire logic                          ref_clk,                    // clock
  input  wire logic                          reset,                      // sync reset
  input  wire logic [ciu_pkg::CIU_ADDR_W-1:0] reg_addr,                  // byte address
  input  wire logic [ciu_pkg::CIU_DATA_W-1:0] reg_wdata,                 // write data
  input  wire logic                          reg_write,                  // write strobe
  input  wire logic                          reg_read,                   // read strobe
  output logic      [ciu_pkg::CIU_DATA_W-1:0] reg_rdata,                 // read data
  input  wire logic                          brownout_request,           // ch 0
  input  wire logic                          external_pin_request,       // ch 1, pin
  input  wire logic                          watchdog_expiry_request,    // ch 2
  input  wire logic                          watchdog_wake_request,      // ch 3
  input  wire logic [2:0]                    serial_error_request,       // ch 4 causes
  input  wire logic                          serial0_receive_request,    // ch 5
  input  wire logic                          serial0_transmit_request,   // ch 6
  input  wire logic                          serial1_receive_request,    // ch 7
  input  wire logic                          serial1_transmit_request,   // ch 8
  input  wire logic                          power_bus_request,          // ch 9
  input  wire logic                          digital_comparator_request, // ch 10
  input  wire logic [5:0]                    front_end0_request,         // ch 11 causes
  input  wire logic [5:0]                    front_end1_request,         // ch 12 causes
  input  wire logic [5:0]                    front_end2_request,         // ch 13 causes
  input  wire logic                          timer_modulator3_request,   // ch 14
  input  wire logic                          timer_modulator2_request,   // ch 15
  input  wire logic                          timer_modulator1_request,   // ch 16
  input  wire logic                          timer_modulator0_request,   // ch 17
  input  wire logic                          wide_timer_overflow_request, // ch 18
  input  wire logic                          dead_time_fault_request,    // ch 19
  input  wire logic                          wide_timer_compare1_request, // ch 20
  input  wire logic                          wide_timer_capture0_request, // ch 21
  input  wire logic                          wide_timer_compare0_request, // ch 22
  input  wire logic                          power_current_mode_request, // ch 23
  input  wire logic                          conversion_done_request,    // ch 24
  input  wire logic [3:0]                    fault_mux_request,          // ch 25 causes
  input  wire logic [2:0]                    pulse_modulator_3_request,  // ch 26 causes
  input  wire logic [2:0]                    pulse_modulator_2_request,  // ch 27 causes
  input  wire logic [2:0]                    pulse_modulator_1_request,  // ch 28 causes
  input  wire logic [2:0]                    pulse_modulator_0_request,  // ch 29 causes
  input  wire logic                          fault_pin_request,          // ch 30, pin
  output logic                               fast_interrupt_level,       // to core
  output logic                               normal_interrupt_level,     // to core
  output logic                               any_interrupt,              // either level
  output logic      [ciu_pkg::CIU_IDX_W-1:0] fast_vector,                // fast index
  output logic                               fast_vector_valid,          // fast index valid
  output logic      [ciu_pkg::CIU_IDX_W-1:0] normal_vector,              // normal index
  output logic                               normal_vector_valid         // normal index valid
);
  import ciu_pkg::*;

  // ==========================================================================
  // state
  logic [CIU_SYNC_LEN-1:0]  ext_sync_q;
  logic [CIU_SYNC_LEN-1:0]  fpin_sync_q;
  logic [CIU_CHANNELS-1:0]  raw_req;
  logic [CIU_CHANNELS-1:0]  prev_req_q;
  logic [CIU_CHANNELS-1:0]  hw_set;
  logic [CIU_CHANNELS-1:0]  pend_q;
  logic [CIU_CHANNELS-1:0]  pend_d;
  logic [CIU_CHANNELS-1:0]  miss_q;
  logic [CIU_CHANNELS-1:0]  miss_d;
  logic [CIU_CHANNELS-1:0]  enable_q;
  logic [CIU_CHANNELS-1:0]  fast_sel_q;
  logic [CIU_CHANNELS-1:0]  edge_sel_q;
  logic [CIU_CHANNELS-1:0]  soft_set;
  logic [CIU_CHANNELS-1:0]  pend_clr;
  logic [CIU_CHANNELS-1:0]  miss_clr;
  logic [CIU_CHANNELS-1:0]  fast_elig;
  logic [CIU_CHANNELS-1:0]  norm_elig;
  logic [CIU_IDX_W-1:0]     fast_idx;
  logic                     fast_found;
  logic [CIU_IDX_W-1:0]     norm_idx;
  logic                     norm_found;
  logic [CIU_DATA_W-1:0]    rdata_d;
  logic                     wr_pend;
  logic                     wr_soft;
  logic                     wr_miss;
  logic                     wr_enable;
  logic                     wr_fast_sel;
  logic                     wr_edge_sel;

  // ==========================================================================
  // pin synchronisers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      ext_sync_q <= '0;
    else
      ext_sync_q <= {ext_sync_q[0], external_pin_request};
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      fpin_sync_q <= '0;
    else
      fpin_sync_q <= {fpin_sync_q[0], fault_pin_request};
  end

  // ==========================================================================
  // channel map
  always_comb
  begin
    raw_req                       = '0;
    raw_req[CIU_CH_BROWNOUT]      = brownout_request;                      // R07
    raw_req[CIU_CH_EXT_PIN]       = ext_sync_q[CIU_SYNC_LEN-1];            // R07
    raw_req[CIU_CH_WD_EXPIRY]     = watchdog_expiry_request;               // R08
    raw_req[CIU_CH_WD_WAKE]       = watchdog_wake_request;                 // R08
    raw_req[CIU_CH_SER_ERR]       = |serial_error_request;                 // R09
    raw_req[CIU_CH_SER0_RX]       = serial0_receive_request;               // R10
    raw_req[CIU_CH_SER0_TX]       = serial0_transmit_request;              // R10
    raw_req[CIU_CH_SER1_RX]       = serial1_receive_request;               // R10
    raw_req[CIU_CH_SER1_TX]       = serial1_transmit_request;              // R10
    raw_req[CIU_CH_PWR_BUS]       = power_bus_request;                     // R11
    raw_req[CIU_CH_DIG_COMP]      = digital_comparator_request;            // R11
    raw_req[CIU_CH_FRONT_END0]    = |front_end0_request;                   // R12
    raw_req[CIU_CH_FRONT_END0+1]  = |front_end1_request;                   // R12
    raw_req[CIU_CH_FRONT_END0+2]  = |front_end2_request;                   // R12
    raw_req[CIU_CH_TMOD3]         = timer_modulator3_request;              // R13
    raw_req[CIU_CH_TMOD3+1]       = timer_modulator2_request;              // R13
    raw_req[CIU_CH_TMOD3+2]       = timer_modulator1_request;              // R13
    raw_req[CIU_CH_TMOD3+3]       = timer_modulator0_request;              // R13
    raw_req[CIU_CH_WT_OVF]        = wide_timer_overflow_request;           // R14
    raw_req[CIU_CH_DT_FAULT]      = dead_time_fault_request;               // R14
    raw_req[CIU_CH_WT_CMP1]       = wide_timer_compare1_request;           // R14
    raw_req[CIU_CH_WT_CAP0]       = wide_timer_capture0_request;           // R14
    raw_req[CIU_CH_WT_CMP0]       = wide_timer_compare0_request;           // R14
    raw_req[CIU_CH_PWR_CUR]       = power_current_mode_request;            // R15
    raw_req[CIU_CH_CONV_DONE]     = conversion_done_request;               // R11
    raw_req[CIU_CH_FAULT_MUX]     = |fault_mux_request;                    // R16
    raw_req[CIU_CH_PMOD3]         = |pulse_modulator_3_request;            // R17
    raw_req[CIU_CH_PMOD3+1]       = |pulse_modulator_2_request;            // R17
    raw_req[CIU_CH_PMOD3+2]       = |pulse_modulator_1_request;            // R17
    raw_req[CIU_CH_PMOD3+3]       = |pulse_modulator_0_request;            // R17
    raw_req[CIU_CH_FAULT_PIN]     = fpin_sync_q[CIU_SYNC_LEN-1];           // R16
    // software channel has no line; it is raised through the set register
    raw_req[CIU_CH_SOFTWARE]      = 1'b0;
  end

  // ==========================================================================
  // request capture: edge or level per channel
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      prev_req_q <= '0;
    else
      prev_req_q <= raw_req;
  end

  // a held line sets pending once in edge mode, every cycle in level mode
  always_comb
  begin
    hw_set = raw_req & (~edge_sel_q | ~prev_req_q); // R01
  end

  // ==========================================================================
  // register write decode
  always_comb
  begin
    wr_pend  = reg_write && (reg_addr == CIU_PEND_OFS);
    wr_soft  = reg_write && (reg_addr == CIU_SOFT_SET_OFS);
    wr_miss  = reg_write && (reg_addr == CIU_MISS_OFS);
    wr_enable   = reg_write && (reg_addr == CIU_ENABLE_OFS);
    wr_fast_sel = reg_write && (reg_addr == CIU_FAST_SEL_OFS);
    wr_edge_sel = reg_write && (reg_addr == CIU_EDGE_SEL_OFS);
    pend_clr = wr_pend ? reg_wdata : '0;
    soft_set = wr_soft ? reg_wdata : '0;
    miss_clr = wr_miss ? reg_wdata : '0;
  end

  // ==========================================================================
  // pending flags: set beats write-one-to-clear
  always_comb
  begin
    pend_d = (pend_q & ~pend_clr) | hw_set | soft_set; // R18
    miss_d = (miss_q & ~miss_clr) | (pend_q & ~pend_clr & (hw_set | soft_set));
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      pend_q <= CIU_PEND_RST;
    else
      pend_q <= pend_d; // R05
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      miss_q <= CIU_PEND_RST;
    else
      miss_q <= miss_d;
  end

  // ==========================================================================
  // configuration registers
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      enable_q <= CIU_ENABLE_RST;
    else if (wr_enable)
      enable_q <= reg_wdata; // R06
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      fast_sel_q <= CIU_FAST_SEL_RST;
    else if (wr_fast_sel)
      fast_sel_q <= reg_wdata;
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      edge_sel_q <= CIU_EDGE_SEL_RST;
    else if (wr_edge_sel)
      edge_sel_q <= reg_wdata;
  end

  // ==========================================================================
  // level split and vector selection
  always_comb
  begin
    fast_elig = pend_q & enable_q & fast_sel_q;  // R18
    norm_elig = pend_q & enable_q & ~fast_sel_q; // R18
  end

  ciu_prio_enc u_fast_enc (
    .request_in (fast_elig),
    .index_out  (fast_idx),
    .found_out  (fast_found)
  );

  ciu_prio_enc u_norm_enc (
    .request_in (norm_elig),
    .index_out  (norm_idx),
    .found_out  (norm_found)
  );

  // fast level with its vector and valid flag
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      fast_interrupt_level <= 1'b0;
      fast_vector          <= '0;
      fast_vector_valid    <= 1'b0;
    end
    else
    begin
      fast_interrupt_level <= fast_found; // R02
      fast_vector          <= fast_idx;   // R03
      fast_vector_valid    <= fast_found;
    end
  end

  // normal level held off while the fast level is pending
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      normal_interrupt_level <= 1'b0;
      normal_vector          <= '0;
      normal_vector_valid    <= 1'b0;
    end
    else
    begin
      normal_interrupt_level <= norm_found && !fast_found; // R02
      normal_vector          <= norm_idx;                  // R03
      normal_vector_valid    <= norm_found;
    end
  end

  // either level, for a core with a single interrupt input
  always_ff @(posedge ref_clk)
  begin
    if (reset)
      any_interrupt <= 1'b0;
    else
      any_interrupt <= fast_found || norm_found;
  end

  // ==========================================================================
  // read path: data only in the cycle after the strobe
  always_comb
  begin
    rdata_d = '0;
    if (reg_read)
    begin
      case (reg_addr)
        CIU_PEND_OFS:     rdata_d = pend_q;
        CIU_ENABLE_OFS:   rdata_d = enable_q;
        CIU_FAST_SEL_OFS: rdata_d = fast_sel_q;
        CIU_FAST_VEC_OFS:
        begin
          rdata_d[CIU_IDX_W-1:0]       = fast_idx;   // R03
          rdata_d[CIU_VEC_VALID_BIT]   = fast_found;
        end
        CIU_NORM_VEC_OFS:
        begin
          rdata_d[CIU_IDX_W-1:0]       = norm_idx;   // R03
          rdata_d[CIU_VEC_VALID_BIT]   = norm_found;
        end
        CIU_RAW_OFS:      rdata_d = raw_req;
        CIU_EDGE_SEL_OFS: rdata_d = edge_sel_q;
        CIU_MISS_OFS:     rdata_d = miss_q;
        default:          rdata_d = '0;
      endcase
    end
  end

  always_ff @(posedge ref_clk)
  begin
    if (reset)
      reg_rdata <= '0;
    else
      reg_rdata <= rdata_d;
  end

endmodule : ciu_top
`default_nettype wire

// [testbench/ciu_properties.sv]
`timescale 1ns/100ps
`default_nettype none
module ciu_properties (
  input wire logic        ref_clk,                // clock
  input wire logic        reset,                  // sync reset
  input wire logic        reg_write,              // write strobe
  input wire logic        reg_read,               // read strobe
  input wire logic [31:0] reg_rdata,              // read data
  input wire logic        fast_interrupt_level,   // fast level
  input wire logic        normal_interrupt_level, // normal level
  input wire logic        any_interrupt,          // either level
  input wire logic [4:0]  fast_vector,            // fast index
  input wire logic        fast_vector_valid,      // fast index valid
  input wire logic [4:0]  normal_vector,          // normal index
  input wire logic        normal_vector_valid     // normal index valid
);
  import ciu_pkg::*;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (reset);

  // ==========================================================================
  // levels and vectors
  a_fast_beats_normal: assert property (fast_interrupt_level |-> !normal_interrupt_level)
    else $error("normal level high beside fast level");
  a_any_is_either: assert property (
    any_interrupt == (fast_interrupt_level || normal_interrupt_level))
    else $error("any output differs from the two levels");
  a_fast_vec_valid: assert property (fast_vector_valid == fast_interrupt_level)
    else $error("fast valid differs from fast level");
  a_norm_vec_valid: assert property (
    normal_interrupt_level == (normal_vector_valid && !fast_interrupt_level))
    else $error("normal level differs from its valid");
  a_fast_vec_drop: assert property (
    fast_vector_valid && $past(fast_vector_valid) && fast_vector < $past(fast_vector)
    |-> $past(reg_write, 2))
    else $error("fast vector fell without a write");
  a_norm_vec_drop: assert property (
    normal_vector_valid && $past(normal_vector_valid) && normal_vector < $past(normal_vector)
    |-> $past(reg_write, 2))
    else $error("normal vector fell without a write");

  // ==========================================================================
  // pending holds until software acts; read data stays zero outside a read reply
  a_fast_held: assert property ($fell(fast_interrupt_level) |-> $past(reg_write, 2))
    else $error("fast level fell without a write");
  a_norm_held: assert property (
    $fell(normal_interrupt_level) |-> $past(reg_write, 2) || fast_interrupt_level)
    else $error("normal level fell without cause");
  a_rdata_idle: assert property (!$past(reg_read) |-> reg_rdata == 32'h0000_0000)
    else $error("read data not zero outside read reply");
endmodule : ciu_properties

bind ciu_top ciu_properties ciu_properties_i (
  .ref_clk(ref_clk), .reset(reset), .reg_write(reg_write), .reg_read(reg_read),
  .reg_rdata(reg_rdata), .fast_interrupt_level(fast_interrupt_level),
  .normal_interrupt_level(normal_interrupt_level), .any_interrupt(any_interrupt),
  .fast_vector(fast_vector), .fast_vector_valid(fast_vector_valid),
  .normal_vector(normal_vector), .normal_vector_valid(normal_vector_valid)
);
`default_nettype wire

// [testbench/ciu_core_model.sv]
`timescale 1ns/100ps
`default_nettype none
module ciu_core_model (
  input  wire logic       ref_clk,     // clock
  input  wire logic       reset,       // sync reset
  input  wire logic       fast_in,     // fast level
  input  wire logic       normal_in,   // normal level
  input  wire logic [4:0] fast_idx,    // fast vector
  input  wire logic [4:0] normal_idx,  // normal vector
  output logic      [4:0] entry_idx_q, // vector taken
  output logic            entry_fast_q // taken on fast level
);
  import ciu_pkg::*;
  // ==========================================================================
  // handler entry, fast level served first
  always_ff @(posedge ref_clk)
  begin
    if (reset)
    begin
      entry_idx_q  <= 5'h00;
      entry_fast_q <= 1'b0;
    end
    else if (fast_in)
    begin
      entry_idx_q  <= fast_idx;
      entry_fast_q <= 1'b1;
    end
    else if (normal_in)
    begin
      entry_idx_q  <= normal_idx;
      entry_fast_q <= 1'b0;
    end
  end
endmodule : ciu_core_model
`default_nettype wire

// [testbench/ciu_top_tb.sv]
`timescale 1ns/100ps
`default_nettype none
module ciu_top_tb;
  import ciu_pkg::*;
  logic        ref_clk   = 1'b0;
  logic        reset     = 1'b1;
  logic [7:0]  reg_addr  = 8'h00;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_write = 1'b0;
  logic        reg_read  = 1'b0;
  logic [31:0] reg_rdata;
  logic [30:0] rq        = 31'h0;
  logic [5:0]  cm        = 6'h01;
  logic        f_lvl, n_lvl, any_int, f_ok, n_ok, e_fast;
  logic [4:0]  f_vec, n_vec, e_idx;
  int          error_cnt = 0;
  int          checks    = 0;
  int          ch;

  always #2 ref_clk = ~ref_clk;

  ciu_top ciu_top_i (
    .ref_clk(ref_clk), .reset(reset), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .brownout_request(rq[0]), .external_pin_request(rq[1]),
    .watchdog_expiry_request(rq[2]), .watchdog_wake_request(rq[3]),
    .serial_error_request({3{rq[4]}} & cm[2:0]), .serial0_receive_request(rq[5]),
    .serial0_transmit_request(rq[6]), .serial1_receive_request(rq[7]),
    .serial1_transmit_request(rq[8]), .power_bus_request(rq[9]),
    .digital_comparator_request(rq[10]), .front_end0_request({6{rq[11]}} & cm),
    .front_end1_request({6{rq[12]}} & cm), .front_end2_request({6{rq[13]}} & cm),
    .timer_modulator3_request(rq[14]), .timer_modulator2_request(rq[15]),
    .timer_modulator1_request(rq[16]), .timer_modulator0_request(rq[17]),
    .wide_timer_overflow_request(rq[18]), .dead_time_fault_request(rq[19]),
    .wide_timer_compare1_request(rq[20]), .wide_timer_capture0_request(rq[21]),
    .wide_timer_compare0_request(rq[22]), .power_current_mode_request(rq[23]),
    .conversion_done_request(rq[24]), .fault_mux_request({4{rq[25]}} & cm[3:0]),
    .pulse_modulator_3_request({3{rq[26]}} & cm[2:0]),
    .pulse_modulator_2_request({3{rq[27]}} & cm[2:0]),
    .pulse_modulator_1_request({3{rq[28]}} & cm[2:0]),
    .pulse_modulator_0_request({3{rq[29]}} & cm[2:0]), .fault_pin_request(rq[30]),
    .fast_interrupt_level(f_lvl), .normal_interrupt_level(n_lvl), .any_interrupt(any_int),
    .fast_vector(f_vec), .fast_vector_valid(f_ok), .normal_vector(n_vec),
    .normal_vector_valid(n_ok)
  );

  ciu_core_model ciu_core_model_i (.ref_clk(ref_clk), .reset(reset), .fast_in(f_lvl),
    .normal_in(n_lvl), .fast_idx(f_vec), .normal_idx(n_vec), .entry_idx_q(e_idx),
    .entry_fast_q(e_fast));

  // ==========================================================================
  // tasks
  task automatic chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk

  task automatic bus(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    reg_write <= wr;
    reg_read  <= !wr;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge ref_clk);
    reg_write <= 1'b0;
    reg_read  <= 1'b0;
    #1;
    if (!wr)
      chk($sformatf("reg %h", a), reg_rdata, d);
  endtask : bus

  task automatic set_rq(input logic [30:0] v, input int c);
    @(posedge ref_clk);
    rq <= v;
    cm <= 6'(1 << (c % 3));
  endtask : set_rq

  // outputs settle within a few cycles; levels, any and the live vector
  task automatic expect_out(input logic f, input logic n, input logic [4:0] v);
    int k;
    logic [9:0] seen;
    for (k = 0; k < 10; k++)
    begin
      @(posedge ref_clk);
      #1;
      seen = {f_ok, n_ok, f_lvl, n_lvl, any_int, f ? f_vec : n ? n_vec : v};
      if (seen === {f, n, f, n, f | n, v})
        break;
    end
    chk("outputs", 32'(seen), 32'({f, n, f, n, f | n, v}));
    if (k == 10)
      print_verdict();
  endtask : expect_out

  task automatic print_verdict();
    $display("checks %0d error_cnt %0d", checks, error_cnt);
    if (error_cnt == 0 && checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask : print_verdict

  // ==========================================================================
  // sequence
  initial
  begin
    #200000;
    error_cnt++;
    print_verdict();
  end

  initial
  begin
    repeat (2) @(posedge ref_clk);
    reset <= 1'b0;
    bus(1'b0, CIU_PEND_OFS, CIU_PEND_RST);
    bus(1'b0, CIU_ENABLE_OFS, CIU_ENABLE_RST);
    bus(1'b0, CIU_FAST_SEL_OFS, CIU_FAST_SEL_RST);
    bus(1'b0, CIU_EDGE_SEL_OFS, CIU_EDGE_SEL_RST);
    bus(1'b0, 8'h40, 32'h0);
    bus(1'b1, CIU_ENABLE_OFS, 32'hFFFF_FFFF);
    bus(1'b0, CIU_ENABLE_OFS, 32'hFFFF_FFFF);
    for (ch = 0; ch < 32; ch++)
    begin
      if (ch < 31)
        set_rq(31'h1 << ch, ch);
      else
        bus(1'b1, CIU_SOFT_SET_OFS, 32'h8000_0000);
      expect_out(1'b0, 1'b1, 5'(ch));
      set_rq(31'h0, ch);
      bus(1'b0, CIU_PEND_OFS, 32'h1 << ch);
      bus(1'b1, CIU_PEND_OFS, 32'h1 << ch);
      expect_out(1'b0, 1'b0, 5'h00);
    end
    set_rq(31'h0010_0020, 5);
    expect_out(1'b0, 1'b1, 5'h14);
    bus(1'b1, CIU_FAST_SEL_OFS, 32'h0010_0020);
    expect_out(1'b1, 1'b0, 5'h14);
    bus(1'b1, CIU_PEND_OFS, 32'h0010_0000);
    chk("core entry", 32'({e_fast, e_idx}), 32'h34);
    expect_out(1'b1, 1'b0, 5'h05);
    bus(1'b0, CIU_FAST_VEC_OFS, 32'h0000_0105);
    bus(1'b1, CIU_SOFT_SET_OFS, 32'h8000_0000);
    bus(1'b1, CIU_FAST_SEL_OFS, 32'h0);
    expect_out(1'b0, 1'b1, 5'h1F);
    bus(1'b1, CIU_ENABLE_OFS, 32'h7FFF_FFFF);
    expect_out(1'b0, 1'b1, 5'h05);
    bus(1'b0, CIU_PEND_OFS, 32'h8000_0020);
    bus(1'b1, CIU_ENABLE_OFS, 32'hFFFF_FFFF);
    expect_out(1'b0, 1'b1, 5'h1F);
    bus(1'b1, CIU_PEND_OFS, 32'h8000_0020);
    expect_out(1'b0, 1'b0, 5'h00);
    bus(1'b1, CIU_EDGE_SEL_OFS, 32'hFFEF_FFFF);
    expect_out(1'b0, 1'b1, 5'h14);
    bus(1'b0, CIU_NORM_VEC_OFS, 32'h0000_0114);
    bus(1'b0, CIU_RAW_OFS, 32'h0010_0020);
    bus(1'b1, CIU_PEND_OFS, 32'h0010_0000);
    bus(1'b0, CIU_PEND_OFS, 32'h0010_0000);
    set_rq(31'h0, 0);
    bus(1'b1, CIU_PEND_OFS, 32'h0010_0000);
    bus(1'b0, CIU_MISS_OFS, 32'h0010_0000);
    bus(1'b1, CIU_MISS_OFS, 32'h0010_0000);
    bus(1'b0, CIU_MISS_OFS, 32'h0);
    expect_out(1'b0, 1'b0, 5'h00);
    print_verdict();
  end
endmodule : ciu_top_tb
`default_nettype wire
